//--- rtl/apt_reg_map.vh
// Register map, field positions, reset values and encodings of the
// ambient/proximity threshold debounce block.
// Assumes a 32-bit classic Wishbone bus; each 8-bit register takes one word.
`ifndef APT_REG_MAP_VH
`define APT_REG_MAP_VH

// Register indices; byte address is four times the index.
`define APT_IDX_RANGE_CFG 6'h12
`define APT_IDX_AMB_HYST 6'h16
`define APT_IDX_PROX_HYST 6'h17
`define APT_IDX_PROX_PERSIST 6'h18
`define APT_IDX_AMB_PERSIST 6'h19
`define APT_IDX_IRQ_STATUS 6'h20
`define APT_IDX_IRQ_MASK 6'h21
`define APT_IDX_LIVE_STATE 6'h22

// Word index sits above the two byte-offset bits of the address.
`define APT_ADR_IDX_MSB 7
`define APT_ADR_IDX_LSB 2

// Reset values.
`define APT_RST_RANGE_CFG 8'h00
`define APT_RST_AMB_HYST 8'h48
`define APT_RST_PROX_HYST 8'h48
`define APT_RST_PROX_PERSIST 8'h03
`define APT_RST_AMB_PERSIST 8'h03
`define APT_RST_IRQ_STATUS 5'h00
`define APT_RST_IRQ_MASK 5'h00

// Field positions.
`define APT_HIGH_RANGE_BIT 5
`define APT_HIGH_RANGE_MASK 8'h20

// Channel numbering of status, mask and live state bits.
`define APT_NUM_CH 5
`define APT_CH_AMB_LOW 0
`define APT_CH_AMB_HIGH 1
`define APT_CH_PROX_FIRST 2

// Compressed format: high nibble exponent, low nibble mantissa.
`define APT_CMP_HIDDEN 5'h10
`define APT_CMP_SHIFT 4

`endif

//--- rtl/apt_hyst_compare.v
// Compares one 16-bit sample with one threshold widened by a hysteresis band.
// Assumes the sample, threshold and hysteresis code are stable while valid.
`timescale 1ns/1ps
`include "apt_reg_map.vh"

module apt_hyst_compare #(
    parameter BELOW = 0
) (
    input wire [15:0] sample,
    input wire [15:0] threshold,
    input wire [7:0] hyst_code,
    input wire state,
    output wire pass
);

    // Expands the 8-bit compressed code to a 16-bit count; 0x48 gives 24.
    function [15:0] apt_expand;
        input [7:0] code;
        reg [19:0] wide;
        begin
            wide = {15'h0000, `APT_CMP_HIDDEN | {1'b0, code[3:0]}} << code[7:4];
            apt_expand = wide[19:4];
        end
    endfunction

    wire [16:0] hyst = {1'b0, apt_expand(hyst_code)};
    wire [16:0] upper = {1'b0, threshold} + hyst;
    wire [16:0] lower = ({1'b0, threshold} > hyst) ? {1'b0, threshold} - hyst : 17'h00000;
    wire [16:0] smp = {1'b0, sample};
    wire go_high = smp > upper;
    wire go_low = smp < lower;

    // Out of the band in the direction that would change the state.
    assign pass = (BELOW != 0) ? (state ? go_high : go_low) : (state ? go_low : go_high);

endmodule // apt_hyst_compare

//--- rtl/apt_persist_filter.v
// Holds one channel's status and changes it only after a persistent run.
// Assumes sample_valid is a one-cycle pulse per new measurement.
`timescale 1ns/1ps
`include "apt_reg_map.vh"

module apt_persist_filter (
    input wire clk,
    input wire rst_n,
    input wire sample_valid,
    input wire pass,
    input wire [7:0] persist_mask,
    output reg state_r,
    output reg change_r
);

    reg [7:0] hist_r;
    wire [7:0] hist_nxt = {hist_r[6:0], pass};
    // A zero mask would flip status on every sample, so the newest sample is always required.
    wire [7:0] need = persist_mask | 8'h01;
    wire fire = sample_valid && ((hist_nxt & need) == need);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_r <= 8'h00;
            state_r <= 1'b0;
            change_r <= 1'b0;
        end else begin
            change_r <= fire;
            if (fire) begin
                // The run restarts so the way back needs its own run.
                hist_r <= 8'h00;
                state_r <= ~state_r;
            end else if (sample_valid) begin
                hist_r <= hist_nxt;
            end
        end
    end

endmodule // apt_persist_filter

//--- rtl/apt_threshold_debounce.v
// Ambient range select, hysteresis and persistence for ambient and
// proximity threshold status, with a classic Wishbone register port.
// Assumes measurements and thresholds arrive synchronous to CORE_CLK.
//
// Functional notes
// - Bit 5 of the visible range word picks normal (0) or high signal range with gain over 14.5 (1).
// - On sequencer revision A02 or earlier the visible range choice also drives infrared measurements.
// - The ambient hysteresis widens both the ambient low and the ambient high threshold.
// - The ambient hysteresis is an 8-bit compressed code for a 16-bit count, 0x48 being 24 codes.
// - The proximity hysteresis, in the same format, widens all three proximity thresholds.
// - Proximity status changes only after the run of samples the proximity persistence asks for.
// - Ambient status changes only after the run of samples the ambient persistence asks for.
`timescale 1ns/1ps
`include "apt_reg_map.vh"

module apt_threshold_debounce (
    input wire CORE_CLK,
    input wire RESET_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire LEGACY_SEQUENCER,
    input wire AMBIENT_VALID,
    input wire [15:0] VISIBLE_AMBIENT_MEASUREMENT,
    input wire [15:0] AMBIENT_LOW_THRESHOLD,
    input wire [15:0] AMBIENT_HIGH_THRESHOLD,
    input wire PROXIMITY_VALID,
    input wire [15:0] PROXIMITY_SAMPLE_FIRST,
    input wire [15:0] PROXIMITY_SAMPLE_SECOND,
    input wire [15:0] PROXIMITY_SAMPLE_THIRD,
    input wire [15:0] PROXIMITY_THRESHOLD_FIRST,
    input wire [15:0] PROXIMITY_THRESHOLD_SECOND,
    input wire [15:0] PROXIMITY_THRESHOLD_THIRD,
    output reg VISIBLE_HIGH_RANGE_SELECT,
    output reg INFRARED_HIGH_RANGE_SELECT,
    output wire AMBIENT_BELOW_LOW,
    output wire AMBIENT_ABOVE_HIGH,
    output wire [2:0] PROXIMITY_NEAR,
    output wire IRQ
);

    reg [7:0] range_cfg_r;
    reg [7:0] amb_hyst_r;
    reg [7:0] prox_hyst_r;
    reg [7:0] prox_persist_r;
    reg [7:0] amb_persist_r;
    reg [4:0] irq_status_r;
    reg [4:0] irq_mask_r;
    reg [4:0] irq_status_nxt;
    reg [31:0] rd_nxt;

    wire [5:0] idx = WB_ADR_I[`APT_ADR_IDX_MSB:`APT_ADR_IDX_LSB];
    wire req = WB_CYC_I && WB_STB_I;
    // Writes land on the edge after the one that shows ack to the master.
    wire wr_en = req && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
    wire [7:0] wd = WB_DAT_I[7:0];

    // Per channel: sample, threshold, hysteresis, persistence, validity.
    wire [15:0] ch_sample [0:`APT_NUM_CH-1];
    wire [15:0] ch_thresh [0:`APT_NUM_CH-1];
    wire [`APT_NUM_CH-1:0] ch_valid;
    wire [`APT_NUM_CH-1:0] ch_pass;
    wire [`APT_NUM_CH-1:0] ch_state;
    wire [`APT_NUM_CH-1:0] ch_change;

    assign ch_sample[0] = VISIBLE_AMBIENT_MEASUREMENT;
    assign ch_sample[1] = VISIBLE_AMBIENT_MEASUREMENT;
    assign ch_sample[2] = PROXIMITY_SAMPLE_FIRST;
    assign ch_sample[3] = PROXIMITY_SAMPLE_SECOND;
    assign ch_sample[4] = PROXIMITY_SAMPLE_THIRD;
    assign ch_thresh[0] = AMBIENT_LOW_THRESHOLD;
    assign ch_thresh[1] = AMBIENT_HIGH_THRESHOLD;
    assign ch_thresh[2] = PROXIMITY_THRESHOLD_FIRST;
    assign ch_thresh[3] = PROXIMITY_THRESHOLD_SECOND;
    assign ch_thresh[4] = PROXIMITY_THRESHOLD_THIRD;
    assign ch_valid = {{3{PROXIMITY_VALID}}, {2{AMBIENT_VALID}}};

    genvar g;
    generate
        for (g = 0; g < `APT_NUM_CH; g = g + 1) begin : g_ch
            // Channels below the proximity group use the ambient settings.
            localparam IS_AMB = (g < `APT_CH_PROX_FIRST);
            apt_hyst_compare #(
                .BELOW(g == `APT_CH_AMB_LOW)
            ) u_cmp (
                .sample(ch_sample[g]),
                .threshold(ch_thresh[g]),
                .hyst_code(IS_AMB ? amb_hyst_r : prox_hyst_r),
                .state(ch_state[g]),
                .pass(ch_pass[g])
            );
            apt_persist_filter u_pst (
                .clk(CORE_CLK),
                .rst_n(RESET_N),
                .sample_valid(ch_valid[g]),
                .pass(ch_pass[g]),
                .persist_mask(IS_AMB ? amb_persist_r : prox_persist_r),
                .state_r(ch_state[g]),
                .change_r(ch_change[g])
            );
        end
    endgenerate

    assign AMBIENT_BELOW_LOW = ch_state[`APT_CH_AMB_LOW];
    assign AMBIENT_ABOVE_HIGH = ch_state[`APT_CH_AMB_HIGH];
    assign PROXIMITY_NEAR = ch_state[`APT_NUM_CH-1:`APT_CH_PROX_FIRST];
    assign IRQ = |(irq_status_r & irq_mask_r);

    // A status change in the same cycle as a write-one clear stays set.
    always @* begin
        irq_status_nxt = irq_status_r;
        if (wr_en && idx == `APT_IDX_IRQ_STATUS) begin
            irq_status_nxt = irq_status_nxt & ~wd[`APT_NUM_CH-1:0];
        end
        irq_status_nxt = irq_status_nxt | ch_change;
    end

    always @* begin
        rd_nxt = 32'h00000000;
        case (idx)
            `APT_IDX_RANGE_CFG: rd_nxt[7:0] = range_cfg_r;
            `APT_IDX_AMB_HYST: rd_nxt[7:0] = amb_hyst_r;
            `APT_IDX_PROX_HYST: rd_nxt[7:0] = prox_hyst_r;
            `APT_IDX_PROX_PERSIST: rd_nxt[7:0] = prox_persist_r;
            `APT_IDX_AMB_PERSIST: rd_nxt[7:0] = amb_persist_r;
            `APT_IDX_IRQ_STATUS: rd_nxt[`APT_NUM_CH-1:0] = irq_status_r;
            `APT_IDX_IRQ_MASK: rd_nxt[`APT_NUM_CH-1:0] = irq_mask_r;
            `APT_IDX_LIVE_STATE: rd_nxt[`APT_NUM_CH-1:0] = ch_state;
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // One wait state: ack rises the cycle after the request and drops after one cycle.
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= req && !WB_ACK_O;
            if (req && !WB_ACK_O) begin
                WB_DAT_O <= rd_nxt;
            end
        end
    end

    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            range_cfg_r <= `APT_RST_RANGE_CFG;
            amb_hyst_r <= `APT_RST_AMB_HYST;
            prox_hyst_r <= `APT_RST_PROX_HYST;
            prox_persist_r <= `APT_RST_PROX_PERSIST;
            amb_persist_r <= `APT_RST_AMB_PERSIST;
            irq_status_r <= `APT_RST_IRQ_STATUS;
            irq_mask_r <= `APT_RST_IRQ_MASK;
        end else begin
            irq_status_r <= irq_status_nxt;
            if (wr_en) begin
                case (idx)
                    // Reserved bits of the range word are kept at zero.
                    `APT_IDX_RANGE_CFG: range_cfg_r <= wd & `APT_HIGH_RANGE_MASK;
                    `APT_IDX_AMB_HYST: amb_hyst_r <= wd;
                    `APT_IDX_PROX_HYST: prox_hyst_r <= wd;
                    `APT_IDX_PROX_PERSIST: prox_persist_r <= wd;
                    `APT_IDX_AMB_PERSIST: amb_persist_r <= wd;
                    `APT_IDX_IRQ_MASK: irq_mask_r <= wd[`APT_NUM_CH-1:0];
                    default: irq_mask_r <= irq_mask_r;
                endcase
            end
        end
    end

    // Range selects are registered so the converter sees glitch-free levels.
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            VISIBLE_HIGH_RANGE_SELECT <= 1'b0;
            INFRARED_HIGH_RANGE_SELECT <= 1'b0;
        end else begin
            VISIBLE_HIGH_RANGE_SELECT <= range_cfg_r[`APT_HIGH_RANGE_BIT];
            // Later sequencers keep infrared in normal range from this block.
            INFRARED_HIGH_RANGE_SELECT <= LEGACY_SEQUENCER &&
                range_cfg_r[`APT_HIGH_RANGE_BIT];
        end
    end

endmodule // apt_threshold_debounce

//--- testbench/apt_td_assertions.sv
// Port-level checker for the threshold debounce block.
// Assumes one clock domain and the one-wait-state register port.
`timescale 1ns/1ps
module apt_td_assertions (
    input wire CORE_CLK,
    input wire RESET_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire LEGACY_SEQUENCER,
    input wire VISIBLE_HIGH_RANGE_SELECT,
    input wire INFRARED_HIGH_RANGE_SELECT,
    input wire AMBIENT_VALID,
    input wire [15:0] VISIBLE_AMBIENT_MEASUREMENT,
    input wire [15:0] AMBIENT_LOW_THRESHOLD,
    input wire [15:0] AMBIENT_HIGH_THRESHOLD,
    input wire AMBIENT_BELOW_LOW,
    input wire AMBIENT_ABOVE_HIGH,
    input wire PROXIMITY_VALID,
    input wire [15:0] PROXIMITY_SAMPLE_FIRST,
    input wire [15:0] PROXIMITY_THRESHOLD_FIRST,
    input wire [2:0] PROXIMITY_NEAR
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    a_ack_one_wait: assert property (s_req |=> WB_ACK_O)
        else $error("ack not one cycle after request");
    a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ir_range_legacy: assert property (
        INFRARED_HIGH_RANGE_SELECT == (VISIBLE_HIGH_RANGE_SELECT && $past(LEGACY_SEQUENCER)))
        else $error("infrared range does not follow visible range");
    a_amb_high_cause: assert property ($changed(AMBIENT_ABOVE_HIGH) |-> $past(AMBIENT_VALID))
        else $error("ambient high state moved without a sample");
    a_amb_low_cause: assert property ($changed(AMBIENT_BELOW_LOW) |-> $past(AMBIENT_VALID))
        else $error("ambient low state moved without a sample");
    a_prox_state_cause: assert property ($changed(PROXIMITY_NEAR) |-> $past(PROXIMITY_VALID))
        else $error("proximity state moved without a sample");
    a_amb_high_set: assert property ($rose(AMBIENT_ABOVE_HIGH) |->
        $past(VISIBLE_AMBIENT_MEASUREMENT) > $past(AMBIENT_HIGH_THRESHOLD))
        else $error("ambient high set at or below threshold");
    a_amb_low_set: assert property ($rose(AMBIENT_BELOW_LOW) |->
        $past(VISIBLE_AMBIENT_MEASUREMENT) < $past(AMBIENT_LOW_THRESHOLD))
        else $error("ambient low set at or above threshold");
    a_prox_near_set: assert property ($rose(PROXIMITY_NEAR[0]) |->
        $past(PROXIMITY_SAMPLE_FIRST) > $past(PROXIMITY_THRESHOLD_FIRST))
        else $error("proximity set at or below threshold");
endmodule // apt_td_assertions
bind apt_threshold_debounce apt_td_assertions u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .LEGACY_SEQUENCER(LEGACY_SEQUENCER), .VISIBLE_HIGH_RANGE_SELECT(VISIBLE_HIGH_RANGE_SELECT),
    .INFRARED_HIGH_RANGE_SELECT(INFRARED_HIGH_RANGE_SELECT), .AMBIENT_VALID(AMBIENT_VALID),
    .VISIBLE_AMBIENT_MEASUREMENT(VISIBLE_AMBIENT_MEASUREMENT),
    .AMBIENT_LOW_THRESHOLD(AMBIENT_LOW_THRESHOLD), .AMBIENT_HIGH_THRESHOLD(AMBIENT_HIGH_THRESHOLD),
    .AMBIENT_BELOW_LOW(AMBIENT_BELOW_LOW), .AMBIENT_ABOVE_HIGH(AMBIENT_ABOVE_HIGH),
    .PROXIMITY_VALID(PROXIMITY_VALID), .PROXIMITY_SAMPLE_FIRST(PROXIMITY_SAMPLE_FIRST),
    .PROXIMITY_THRESHOLD_FIRST(PROXIMITY_THRESHOLD_FIRST), .PROXIMITY_NEAR(PROXIMITY_NEAR));

//--- testbench/apt_meas_src.sv
// Measurement sequencer model: one-cycle valid pulse per requested sample.
// Assumes requests come from the bench one clock ahead of the pulse.
`timescale 1ns/1ps
module apt_meas_src (
    input wire logic clk,
    input wire logic fire,
    input wire logic [15:0] value,
    output logic valid = 1'b0,
    output logic [15:0] sample = 16'h0000
);
    // Outside a pulse the sample is inverted each cycle, so stale data matches the last valid value only every second cycle.
    always @(posedge clk) begin
        valid <= fire;
        sample <= fire ? value : ~sample;
    end
endmodule // apt_meas_src

//--- testbench/apt_threshold_debounce_tb.sv
// Self-checking bench for the threshold debounce block.
// Assumes the one-wait-state register port and one-cycle state latency.
`timescale 1ns/1ps
module apt_threshold_debounce_tb;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, legacy = 0, af = 0, pf = 0;
    logic [7:0] adr = 8'h00, rd;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [15:0] av = 16'h0, pv = 16'h0, lo_th = 16'h0, hi_th = 16'h0, th1 = 16'h0;
    logic [15:0] th_far = 16'hF000;
    wire [31:0] dat_o;
    wire ack, vis, ir, below, above, irq, avld, pvld;
    wire [2:0] near;
    wire [15:0] as, ps;
    int n_mismatch = 0, samples_checked = 0;
    always #5 clk = ~clk;
    apt_meas_src amb (.clk(clk), .fire(af), .value(av), .valid(avld), .sample(as));
    apt_meas_src prx (.clk(clk), .fire(pf), .value(pv), .valid(pvld), .sample(ps));
    apt_threshold_debounce uut (.CORE_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .LEGACY_SEQUENCER(legacy), .AMBIENT_VALID(avld),
        .VISIBLE_AMBIENT_MEASUREMENT(as), .AMBIENT_LOW_THRESHOLD(lo_th),
        .AMBIENT_HIGH_THRESHOLD(hi_th), .PROXIMITY_VALID(pvld), .PROXIMITY_SAMPLE_FIRST(ps),
        .PROXIMITY_SAMPLE_SECOND(ps), .PROXIMITY_SAMPLE_THIRD(ps), .PROXIMITY_THRESHOLD_FIRST(th1),
        .PROXIMITY_THRESHOLD_SECOND(th_far), .PROXIMITY_THRESHOLD_THIRD(th_far),
        .VISIBLE_HIGH_RANGE_SELECT(vis), .INFRARED_HIGH_RANGE_SELECT(ir),
        .AMBIENT_BELOW_LOW(below), .AMBIENT_ABOVE_HIGH(above), .PROXIMITY_NEAR(near), .IRQ(irq));
    task wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wb(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        {adr, sel, dat} <= {i, 2'b00, 4'hF, 24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o[7:0];
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    task send(input bit p, input logic [15:0] v);
        @(posedge clk);
        if (p) {pf, pv} <= {1'b1, v};
        else {af, av} <= {1'b1, v};
        @(posedge clk);
        {pf, af} <= 2'b00;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task t_regs();
        logic [5:0] idx [8] = '{6'h12, 6'h16, 6'h17, 6'h18, 6'h19, 6'h20, 6'h21, 6'h30};
        logic [7:0] rv [8] = '{8'h00, 8'h48, 8'h48, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 8; k++) begin
            wb(1'b0, idx[k], 8'h00, rd);
            chk("reset value", 16'(rv[k]), 16'(rd));
        end
    endtask
    task t_range();
        legacy <= 1'b1;
        wb(1'b1, 6'h12, 8'hFF, rd);
        repeat (2) @(posedge clk);
        #1;
        chk("visible range", 16'h1, 16'(vis));
        chk("infrared range", 16'h1, 16'(ir));
        @(posedge clk);
        legacy <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("infrared range", 16'h0, 16'(ir));
        wb(1'b0, 6'h12, 8'h00, rd);
        chk("range word", 16'h20, 16'(rd));
    endtask
    task t_prox();
        th1 <= 16'h0064;
        wb(1'b1, 6'h21, 8'h04, rd);
        for (int k = 0; k < 4; k++) begin
            send(1'b1, k < 2 ? 16'h007C : 16'h007D);
            chk("near", 16'(k == 3), 16'(near));
        end
        chk("irq", 16'h1, 16'(irq));
        wb(1'b0, 6'h20, 8'h00, rd);
        chk("status", 16'h04, 16'(rd));
        wb(1'b1, 6'h20, 8'h04, rd);
        #1;
        chk("irq", 16'h0, 16'(irq));
    endtask
    task t_amb();
        logic [15:0] v [8] = '{16'h0409, 16'h0408, 16'h0409, 16'h0409, 16'h0409,
            16'h01D3, 16'h01D3, 16'h01D3};
        hi_th <= 16'h03E8;
        lo_th <= 16'h01F4;
        wb(1'b1, 6'h16, 8'h50, rd);
        wb(1'b1, 6'h19, 8'h07, rd);
        for (int k = 0; k < 8; k++) begin
            send(1'b0, v[k]);
            chk("above", 16'(k > 3 && k < 7), 16'(above));
            chk("below", 16'(k == 7), 16'(below));
        end
        wb(1'b0, 6'h22, 8'h00, rd);
        chk("live state", 16'h05, 16'(rd));
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_range();
        t_prox();
        t_amb();
        wrap_up();
    end
endmodule // apt_threshold_debounce_tb
